/* asr_device.sv */
// asr_device: readout port end, configuration map and output shifter
// assumes: host drives select, clock and input data; pins are sampled on aclk
`timescale 1ns/10ps
`default_nettype none
module asr_device (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link
  asr_link_if.device lk,
  // converter side
  input wire logic [15:0] conv_result,
  output logic [1:0] active_mode
);

  // ==========================================
  // pin synchronisers
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;

  asr_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({lk.convert_select_n, lk.sclk, lk.sdi}),
    .q({cs_n_s, sclk_s, sdi_s})
  );

  logic cs_p_q;
  logic sclk_p_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_p_q <= 1'b1;
      sclk_p_q <= 1'b0;
    end else begin
      cs_p_q <= cs_n_s;
      sclk_p_q <= sclk_s;
    end
  end

  logic frame;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  assign frame = !cs_n_s;
  assign cs_fall = cs_p_q && !cs_n_s;
  assign cs_rise = !cs_p_q && cs_n_s;
  assign sclk_rise = sclk_s && !sclk_p_q;
  assign sclk_fall = !sclk_s && sclk_p_q;

  // ==========================================
  // configuration registers
  logic [31:0] cfg_q [asr_pkg::NREG];
  logic [31:0] in_sr_q;
  logic [6:0] bit_cnt_q;
  logic cmd_ok;
  logic [7:0] cmd_op;
  logic [7:0] cmd_addr;
  logic [3:0] cmd_slot;

  assign cmd_ok = cs_rise && (bit_cnt_q >= 7'(asr_pkg::WORD_BITS));
  assign cmd_op = in_sr_q[asr_pkg::CMD_OP_LSB +: 8];
  assign cmd_addr = in_sr_q[asr_pkg::CMD_ADDR_LSB +: 8];
  assign cmd_slot = asr_pkg::slot_of(cmd_addr);

  genvar gi;
  generate
    for (gi = 0; gi < asr_pkg::NREG; gi++) begin : g_reg
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cfg_q[gi] <= asr_pkg::REG_RESET;
        end else if (cmd_ok && cmd_op == asr_pkg::CMD_WRITE && cmd_slot == 4'(gi)) begin
          // one byte per command, reserved bits stay zero
          cfg_q[gi][8*cmd_addr[1:0] +: 8] <= in_sr_q[7:0] & asr_pkg::REG_MASK[gi][8*cmd_addr[1:0] +: 8];
        end
      end
    end
  endgenerate

  // ==========================================
  // mode decode; registers only change between frames
  logic [1:0] imode;
  logic src_mode;
  logic dual;
  logic intclk;
  logic daisy;
  logic cpha;
  logic cap_rise;
  assign imode = cfg_q[asr_pkg::SLOT_IN][asr_pkg::IMODE_LSB +: 2];
  assign src_mode = cfg_q[asr_pkg::SLOT_OUT][asr_pkg::OMODE_LSB +: 2] != asr_pkg::OMODE_SPI;
  assign dual = cfg_q[asr_pkg::SLOT_OUT][asr_pkg::SEC_CFG_LSB +: 2] == asr_pkg::SECOND_DUAL;
  assign intclk = src_mode && cfg_q[asr_pkg::SLOT_OUT][asr_pkg::CLK_SRC_BIT];
  assign daisy = cfg_q[asr_pkg::SLOT_OUT] == '0;
  assign cpha = imode[0];
  assign cap_rise = !(imode[1] ^ imode[0]);

  logic cap_edge;
  logic launch_sclk;
  assign cap_edge = frame && (cap_rise ? sclk_rise : sclk_fall);
  assign launch_sclk = frame && (cap_rise ? sclk_fall : sclk_rise);

  // ==========================================
  // command capture, all writes use the selected mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_sr_q <= '0;
      bit_cnt_q <= '0;
    end else if (cs_fall) begin
      bit_cnt_q <= '0;
    end else if (cap_edge) begin
      in_sr_q <= {in_sr_q[30:0], sdi_s};
      if (!(&bit_cnt_q)) bit_cnt_q <= bit_cnt_q + 7'h01;
    end
  end

  // ==========================================
  // next output word
  logic [31:0] next_word_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      next_word_q <= '0;
    end else if (cs_rise) begin
      if (cmd_ok && cmd_op == asr_pkg::CMD_READ && cmd_slot != asr_pkg::SLOT_NONE) begin
        next_word_q <= {cfg_q[cmd_slot][8*cmd_addr[1:0] +: 8], 24'h00_0000};
      end else begin
        next_word_q <= {conv_result, 16'h0000};
      end
    end
  end

  // ==========================================
  // internal strobe clock
  logic [7:0] int_cnt_q;
  logic int_tick;
  logic [6:0] bits_left_q;
  logic strobe_q;
  logic launch;
  assign int_tick = frame && intclk && int_cnt_q == 8'(asr_pkg::INT_HALF_CYC - 1);
  assign launch = intclk ? (int_tick && strobe_q) : launch_sclk;

  always_ff @(posedge aclk) begin
    if (!aresetn || !frame || !intclk || int_tick) begin
      int_cnt_q <= '0;
    end else begin
      int_cnt_q <= int_cnt_q + 8'h01;
    end
  end

  // ==========================================
  // output shifter
  logic [31:0] out_sr_q;
  logic present_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_sr_q <= '0;
      present_q <= 1'b0;
    end else if (cs_fall) begin
      out_sr_q <= next_word_q;
      present_q <= !cpha || intclk;
    end else if (!frame) begin
      present_q <= 1'b0; // a short frame simply drops the rest
    end else if (launch) begin
      if (!present_q) begin
        present_q <= 1'b1;
      end else if (dual) begin
        out_sr_q <= {out_sr_q[29:0], 2'b00};
      end else begin
        out_sr_q <= {out_sr_q[30:0], daisy ? in_sr_q[0] : 1'b0};
      end
    end
  end

  // ==========================================
  // strobe pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_q <= 1'b0;
      bits_left_q <= '0;
    end else if (cs_fall) begin
      strobe_q <= 1'b0;
      bits_left_q <= 7'(asr_pkg::WORD_BITS);
    end else if (!frame || !src_mode) begin
      strobe_q <= 1'b0;
    end else if (intclk) begin
      if (int_tick && strobe_q) begin
        strobe_q <= 1'b0;
      end else if (int_tick && bits_left_q != '0) begin
        strobe_q <= 1'b1;
        bits_left_q <= bits_left_q - (dual ? 7'h02 : 7'h01);
      end
    end else if (launch_sclk) begin
      strobe_q <= 1'b0;
    end else if (cap_edge) begin
      strobe_q <= 1'b1;
    end
  end

  // ==========================================
  // pin outputs
  logic sdo0_q;
  logic sdo1_q;
  logic strobe_pin_q;
  logic [1:0] active_mode_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sdo0_q <= 1'b0;
      sdo1_q <= 1'b0;
      strobe_pin_q <= 1'b0;
      active_mode_q <= asr_pkg::MODE_00;
    end else begin
      sdo0_q <= frame && present_q && out_sr_q[31];
      sdo1_q <= frame && present_q && dual && out_sr_q[30];
      strobe_pin_q <= strobe_q;
      active_mode_q <= imode;
    end
  end

  assign lk.serial_out_first = sdo0_q;
  assign lk.shared_alarm_pin = sdo1_q;
  assign lk.ready_strobe_pin = strobe_pin_q;
  assign active_mode = active_mode_q;

endmodule
`default_nettype wire

/* asr_host.sv */
// asr_host: host controller end, runs frames on command from AXI4-Lite registers
// assumes: software keeps the mode fields in step with the device
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module asr_host #(
  parameter int HALF_CYC = asr_pkg::LINK_HALF_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // link
  asr_link_if.host lk
);

  typedef enum logic [1:0] {ASR_IDLE, ASR_CLOCK, ASR_TAIL} asr_state_t;
  asr_state_t state_q;

  // ==========================================
  // pin synchronisers
  logic sdo0_s;
  logic sdo1_s;
  logic strobe_s;
  logic strobe_p_q;

  asr_sync #(.W(3), .RST_VAL(3'h0)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({lk.serial_out_first, lk.shared_alarm_pin, lk.ready_strobe_pin}),
    .q({sdo0_s, sdo1_s, strobe_s})
  );

  // ==========================================
  // registers and axi slave
  logic [1:0] mode_q;
  logic src_q;
  logic dual_q;
  logic [7:0] len_q;
  logic [31:0] txd_q;
  logic [31:0] rxd_q;
  logic done_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] wa_q;
  logic [31:0] wd_q;
  logic do_write;
  logic go;
  assign do_write = aw_got_q && w_got_q && !bvalid;
  assign go = do_write && wa_q == asr_pkg::H_CTRL && wd_q[asr_pkg::HC_GO_BIT] && state_q == ASR_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      wa_q <= '0;
      wd_q <= '0;
      bvalid <= 1'b0;
      bresp <= asr_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_q <= 1'b1;
        wa_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_q <= 1'b1;
        wd_q <= wdata;
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (wa_q == asr_pkg::H_CTRL || wa_q == asr_pkg::H_LEN || wa_q == asr_pkg::H_TXD) ?
          asr_pkg::RESP_OKAY : asr_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  assign awready = !aw_got_q && !bvalid;
  assign wready = !w_got_q && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= asr_pkg::MODE_00;
      src_q <= 1'b0;
      dual_q <= 1'b0;
      len_q <= 8'(asr_pkg::WORD_BITS);
      txd_q <= '0;
    end else if (do_write && wstrb != 4'h0) begin
      // the frame started by this same write already runs with the mode written here
      if (wa_q == asr_pkg::H_CTRL) begin
        mode_q <= wd_q[1:0];
        src_q <= wd_q[asr_pkg::HC_SRC_BIT];
        dual_q <= wd_q[asr_pkg::HC_DUAL_BIT];
      end
      if (wa_q == asr_pkg::H_LEN) len_q <= wd_q[7:0];
      if (wa_q == asr_pkg::H_TXD) txd_q <= wd_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= asr_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= asr_pkg::RESP_OKAY;
      case (araddr)
        asr_pkg::H_CTRL: rdata <= {28'h000_0000, dual_q, src_q, mode_q};
        asr_pkg::H_LEN: rdata <= {24'h00_0000, len_q};
        asr_pkg::H_TXD: rdata <= txd_q;
        asr_pkg::H_RXD: rdata <= rxd_q;
        asr_pkg::H_STAT: rdata <= {30'h0000_0000, done_q, state_q != ASR_IDLE};
        default: begin
          rdata <= '0;
          rresp <= asr_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  assign arready = !rvalid;

  // ==========================================
  // frame engine
  logic cs_n_q;
  logic sclk_q;
  logic sdi_q;
  logic [31:0] tx_sr_q;
  logic [8:0] edges_left_q;
  logic [7:0] half_cnt_q;
  logic [7:0] rx_cnt_q;
  logic wrap;
  logic lead;
  logic launch;
  logic capture;
  assign wrap = half_cnt_q == 8'(HALF_CYC - 1);
  assign lead = sclk_q == mode_q[1];
  assign launch = state_q == ASR_CLOCK && wrap && edges_left_q != '0 && (mode_q[0] ? lead : !lead);
  assign capture = state_q != ASR_IDLE && (src_q ? (strobe_s && !strobe_p_q) :
    (state_q == ASR_CLOCK && wrap && edges_left_q != '0 && (mode_q[0] ? !lead : lead)));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ASR_IDLE;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      sdi_q <= 1'b0;
      tx_sr_q <= '0;
      edges_left_q <= '0;
      half_cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      half_cnt_q <= (state_q == ASR_IDLE || wrap) ? 8'h00 : half_cnt_q + 8'h01;
      case (state_q)
        ASR_IDLE: begin
          // a frame started by the write that also sets the mode runs in that mode
          sclk_q <= go ? wd_q[1] : mode_q[1];
          if (go) begin
            state_q <= ASR_CLOCK;
            cs_n_q <= 1'b0;
            done_q <= 1'b0;
            edges_left_q <= {len_q, 1'b0};
            sdi_q <= !wd_q[0] && txd_q[31];
            tx_sr_q <= wd_q[0] ? txd_q : {txd_q[30:0], 1'b0};
          end
        end
        ASR_CLOCK: begin
          if (wrap) begin
            if (edges_left_q == '0) begin
              state_q <= ASR_TAIL;
            end else begin
              sclk_q <= !sclk_q;
              edges_left_q <= edges_left_q - 9'h001;
            end
          end
          if (launch) begin
            sdi_q <= tx_sr_q[31];
            tx_sr_q <= {tx_sr_q[30:0], 1'b0};
          end
        end
        ASR_TAIL: begin
          // let strobes still in flight arrive before closing the frame
          if (wrap && (!src_q || rx_cnt_q >= len_q)) begin
            state_q <= ASR_IDLE;
            cs_n_q <= 1'b1;
            done_q <= 1'b1;
          end
        end
        default: state_q <= ASR_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_q <= '0;
      rx_cnt_q <= '0;
      strobe_p_q <= 1'b0;
    end else begin
      strobe_p_q <= strobe_s;
      if (go) begin
        rx_cnt_q <= '0;
        rxd_q <= '0;
      end else if (capture) begin
        rxd_q <= dual_q ? {rxd_q[29:0], sdo0_s, sdo1_s} : {rxd_q[30:0], sdo0_s};
        rx_cnt_q <= rx_cnt_q + (dual_q ? 8'h02 : 8'h01);
      end
    end
  end

  assign lk.convert_select_n = cs_n_q;
  assign lk.sclk = sclk_q;
  assign lk.sdi = sdi_q;

endmodule
`default_nettype wire

/* asr_link_asserts.sv */
// asr_link_asserts: protocol checks on the link between host controller and readout port
// assumes: the bench instantiates it beside the link interface, one aclk domain
`timescale 1ns/10ps
`default_nettype none
module asr_link_asserts #(
  parameter int HALF_CYC = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // host driven
  input wire logic convert_select_n,
  input wire logic sclk,
  input wire logic sdi,
  // device driven
  input wire logic serial_out_first,
  input wire logic shared_alarm_pin,
  input wire logic ready_strobe_pin
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================
  // helpers
  // set once a strobe is seen in this frame, so source-sync data timing is left out
  logic src_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || $fell(convert_select_n)) begin
      src_q <= 1'b0;
    end else if (ready_strobe_pin) begin
      src_q <= 1'b1;
    end
  end

  sequence s_sclk_quiet;
    $stable(sclk) [*6];
  endsequence

  sequence s_data_held;
    $stable(serial_out_first) && $stable(shared_alarm_pin) ##1 $stable(serial_out_first);
  endsequence

  // ==========================================
  // assertions
  a_reset_host_idle: assert property ($rose(aresetn) |-> convert_select_n && !sclk && !sdi)
    else $error("host link not idle after reset");
  a_reset_dev_quiet: assert property ($rose(aresetn) |-> !serial_out_first && !shared_alarm_pin
    && !ready_strobe_pin)
    else $error("device outputs not low after reset");
  a_sclk_half_period: assert property ($changed(sclk) |=> s_sclk_quiet)
    else $error("serial clock half period too short");
  a_select_lead: assert property ($fell(convert_select_n) |=> s_sclk_quiet)
    else $error("serial clock moved too soon after select fall");
  a_select_tail: assert property ($changed(sclk) && !convert_select_n |=> !convert_select_n [*6])
    else $error("select rose too soon after a clock edge");
  a_data_at_edge: assert property ($changed(sclk) && !convert_select_n && !src_q && !ready_strobe_pin
    |-> s_data_held)
    else $error("output data moved at a clock edge");
  a_strobe_in_frame: assert property ($rose(ready_strobe_pin) |-> !convert_select_n)
    else $error("strobe rose outside a frame");
  a_second_in_frame: assert property ($rose(shared_alarm_pin) |-> !convert_select_n)
    else $error("second output rose outside a frame");
endmodule
`default_nettype wire

/* asr_link_if.sv */
// asr_link_if: serial link between host controller and readout port
// assumes: the bench instantiates it and hands one modport to each end
`timescale 1ns/10ps
`default_nettype none
interface asr_link_if;
  logic convert_select_n;
  logic sclk;
  logic sdi;
  logic serial_out_first;
  logic shared_alarm_pin;
  logic ready_strobe_pin;

  modport device (
    input convert_select_n,
    input sclk,
    input sdi,
    output serial_out_first,
    output shared_alarm_pin,
    output ready_strobe_pin
  );

  modport host (
    output convert_select_n,
    output sclk,
    output sdi,
    input serial_out_first,
    input shared_alarm_pin,
    input ready_strobe_pin
  );
endinterface
`default_nettype wire

/* asr_pkg.sv */
// asr_pkg: shared constants for the serial readout port and its host controller
// assumes: 100 MHz aclk on both ends, 32-bit output word
`default_nettype none
package asr_pkg;

  // ==========================================
  // output word and modes
  localparam int WORD_BITS = 32;
  localparam logic [1:0] MODE_00 = 2'h0;
  localparam logic [1:0] OMODE_SPI = 2'h0;
  localparam logic [1:0] SECOND_DUAL = 2'h3;

  // ==========================================
  // configuration map, byte addressed
  localparam int NREG = 9;
  localparam logic [7:0] REG_OFS [NREG] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28};
  localparam logic [31:0] REG_MASK [NREG] = '{32'h000f_0000, 32'h0000_ff37, 32'h0000_0003, 32'h0000_004f,
    32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [3:0] SLOT_ID = 4'h0;
  localparam logic [3:0] SLOT_IN = 4'h2;
  localparam logic [3:0] SLOT_OUT = 4'h3;
  localparam logic [3:0] SLOT_NONE = 4'hf;

  // field positions
  localparam int IMODE_LSB = 0;
  localparam int OMODE_LSB = 0;
  localparam int SEC_CFG_LSB = 2;
  localparam int CLK_SRC_BIT = 6;
  localparam int CHIP_ADDR_LSB = 16;

  // ==========================================
  // command word: opcode [31:24], byte address [23:16], data [7:0]
  localparam int CMD_OP_LSB = 24;
  localparam int CMD_ADDR_LSB = 16;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h02;

  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_HALF_NS = 80;
  localparam int INT_HALF_NS = 40;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS / CLK_PERIOD_NS < 1) ? 1 : LINK_HALF_NS / CLK_PERIOD_NS;
  localparam int INT_HALF_CYC = (INT_HALF_NS / CLK_PERIOD_NS < 1) ? 1 : INT_HALF_NS / CLK_PERIOD_NS;

  // ==========================================
  // host controller register map
  localparam logic [7:0] H_CTRL = 8'h00;
  localparam logic [7:0] H_LEN = 8'h04;
  localparam logic [7:0] H_TXD = 8'h08;
  localparam logic [7:0] H_RXD = 8'h0c;
  localparam logic [7:0] H_STAT = 8'h10;
  localparam int HC_SRC_BIT = 2;
  localparam int HC_DUAL_BIT = 3;
  localparam int HC_GO_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [3:0] slot_of(input logic [7:0] a);
    logic [3:0] s;
    s = SLOT_NONE;
    for (int i = 0; i < NREG; i++) begin
      if (REG_OFS[i][7:2] == a[7:2]) s = 4'(i);
    end
    return s;
  endfunction

endpackage
`default_nettype wire

/* asr_sync.sv */
// asr_sync: two-flop synchroniser for a group of independent levels
// assumes: each bit is a level from another domain
`timescale 1ns/10ps
`default_nettype none
module asr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* tb_adc_serial_readout_port.sv */
// tb_adc_serial_readout_port: host controller and readout port joined over the link
// assumes: 100 MHz aclk, software access over AXI4-Lite, fixed xorshift seed
`timescale 1ns/10ps
`default_nettype none
module tb_adc_serial_readout_port;
  // ==========================================
  // signals
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, sp_q = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, chip = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, seed = 32'h0000_8921, exp_q = 32'h0000_0000, rw;
  logic [3:0] wstrb = 4'hf;
  logic [15:0] conv_result = 16'h0000;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp, active_mode, rs;
  int mismatches = 0, checks_done = 0, strobe_n = 0;

  asr_link_if lk ();
  asr_device asr_device_inst (.aclk(aclk), .aresetn(aresetn), .lk(lk.device), .conv_result(conv_result),
    .active_mode(active_mode));
  asr_host asr_host_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .lk(lk.host));
  asr_link_asserts #(.HALF_CYC(asr_pkg::LINK_HALF_CYC)) asr_link_asserts_inst (.aclk(aclk), .aresetn(aresetn),
    .convert_select_n(lk.convert_select_n), .sclk(lk.sclk), .sdi(lk.sdi), .serial_out_first(lk.serial_out_first),
    .shared_alarm_pin(lk.shared_alarm_pin), .ready_strobe_pin(lk.ready_strobe_pin));

  always #5 aclk = ~aclk;

  always @(posedge aclk) begin
    sp_q <= lk.ready_strobe_pin;
    if (lk.ready_strobe_pin && !sp_q) strobe_n <= strobe_n + 1;
  end

  // ==========================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // word the device shifts out in the frame after one that carried tx over len clocks
  function automatic logic [31:0] next_word(input logic [31:0] tx, input logic [7:0] len);
    if (len == 8'h20 && tx[31:24] == asr_pkg::CMD_READ) begin
      return {(tx[23:16] == 8'h02 ? chip : 8'h00), 24'h00_0000};
    end
    return {conv_result, 16'h0000};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ha, hw, hb;
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    hb = 1'b0;
    while (!hb && n < 100) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!hb) begin
      mismatches++;
      $display("[ERR] %0t write response missing", $time);
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hv;
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    hv = 1'b0;
    while (!hv && n < 100) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!hv) begin
      mismatches++;
      $display("[ERR] %0t read response missing", $time);
    end
  endtask

  // one frame: ctl is {dual, source-sync, mode}; the word seen is decided by the previous frame
  task automatic frame(input logic [31:0] tx, input logic [7:0] len, input logic [3:0] ctl, input logic cmp);
    logic [31:0] rx, m;
    logic [63:0] v;
    logic [1:0] r;
    logic [7:0] b;
    int n;
    rx = rnd();
    conv_result <= rx[15:0];
    axi_wr(asr_pkg::H_LEN, {24'h00_0000, len}, 4'hf, r);
    axi_wr(asr_pkg::H_TXD, tx, 4'hf, r);
    axi_wr(asr_pkg::H_CTRL, {23'h00_0000, 1'b1, 4'h0, ctl}, 4'hf, r);
    n = 0;
    rx = 32'h0000_0000;
    while (rx[1] !== 1'b1 && n < 3000) begin
      axi_rd(asr_pkg::H_STAT, rx, r);
      n++;
    end
    if (rx[1] !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t frame never finished", $time);
    end
    axi_rd(asr_pkg::H_RXD, rx, r);
    b = ctl[3] ? {len[6:0], 1'b0} : len;
    v = {exp_q, tx} >> (8'h40 - b);
    m = (b >= 8'h20) ? 32'hffff_ffff : (32'h0000_0001 << b) - 32'h0000_0001;
    if (cmp) chk(rx & m, v[31:0] & m);
    exp_q = next_word(tx, len);
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_wr(asr_pkg::H_LEN, 32'h0000_0005, 4'h0, rs);
    axi_rd(asr_pkg::H_LEN, rw, rs);
    chk(rw, 32'h0000_0020);
    axi_wr(8'h40, 32'h0000_0000, 4'hf, rs);
    chk({30'h0, rs}, {30'h0, asr_pkg::RESP_SLVERR});
    axi_rd(8'h40, rw, rs);
    chk({30'h0, rs}, {30'h0, asr_pkg::RESP_SLVERR});
    frame(32'h0000_0000, 8'h20, 4'h0, 1'b0);
    rw = rnd();
    chip = {4'h0, rw[3:0]};
    frame({asr_pkg::CMD_WRITE, 8'h02, 8'h00, rw[7:0]}, 8'h20, 4'h0, 1'b1);
    frame({asr_pkg::CMD_READ, 8'h02, 16'h0000}, 8'h20, 4'h0, 1'b1);
    frame({asr_pkg::CMD_READ, 8'h03, 16'h0000}, 8'h20, 4'h0, 1'b1);
    frame({8'ha5, 8'h00, rw[31:16]}, 8'h28, 4'h0, 1'b1);
    frame(32'h0000_0000, 8'h0c, 4'h0, 1'b1);
    for (int k = 1; k < 5; k++) begin
      frame({asr_pkg::CMD_WRITE, 8'h08, 14'h0000, 2'(k)}, 8'h20, 4'(k - 1), 1'b1);
      chk({30'h0, active_mode}, {30'h0, 2'(k)});
      frame({asr_pkg::CMD_READ, 8'h02, 16'h0000}, 8'h20, {2'h0, 2'(k)}, 1'b1);
    end
    chk(32'(strobe_n), 32'h0000_0000);
    frame({asr_pkg::CMD_WRITE, 8'h0c, 16'h000c}, 8'h20, 4'h0, 1'b1);
    frame(32'h0000_0000, 8'h10, 4'h8, 1'b1);
    frame(32'h0000_0000, 8'h10, 4'h8, 1'b1);
    frame({asr_pkg::CMD_WRITE, 8'h0c, 16'h0001}, 8'h20, 4'h0, 1'b0);
    frame(32'h0000_0000, 8'h20, 4'h4, 1'b1);
    chk(32'(strobe_n), 32'h0000_0020);
    frame({asr_pkg::CMD_WRITE, 8'h0c, 16'h0041}, 8'h20, 4'h4, 1'b1);
    frame(32'h0000_0000, 8'h20, 4'h4, 1'b1);
    chk(32'(strobe_n), 32'h0000_0060);
    summarize();
  end

  initial begin
    #1_000_000;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
endmodule
`default_nettype wire
